// ==== shared/sdp_pkg.sv ====
// sdp_pkg: constants, types and helpers for the sdram pin command interface
// assumes one rising-edge clock shared with the external memory controller

package sdp_pkg;

  // ----------------------------------------------------------------------
  // widths and storage
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int COL_W = 9;
  localparam int DQ_W = 16;
  // row bits kept in the storage index; full array is far too big to model
  localparam int MEM_ROW_BITS = 1;
  localparam int MEM_AW = 2 + MEM_ROW_BITS + COL_W;

  // ----------------------------------------------------------------------
  // command codes {ras_n, cas_n, we_n}
  // ----------------------------------------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------------------------------------
  // mode word field positions and reset values
  // ----------------------------------------------------------------------
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WBS_BIT = 9;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL3_CODE = 3'h3;
  localparam logic [2:0] BL_RST = 3'h0;
  localparam logic CL3_RST = 1'b1;
  localparam logic [9:0] FULL_PAGE_LEN = 10'h200;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PWR_RUN = 4'b0001,
    PWR_SUSP = 4'b0010,
    PWR_PDN = 4'b0100,
    PWR_SREF = 4'b1000
  } sdp_pwr_e;

  typedef struct packed {
    sdp_pwr_e pwr;
    logic [2:0] bl;
    logic bt;
    logic cl3;
    logic wbs;
    logic [3:0] act;
    logic [3:0][ADDR_W-1:0] row;
    logic rd;
    logic wr;
    logic [1:0] bank;
    logic [COL_W-1:0] col0;
    logic [COL_W-1:0] cnt;
    logic [9:0] left;
    logic full;
    logic ap;
    logic [DQ_W-1:0] p0;
    logic v0;
    logic [DQ_W-1:0] p1;
    logic v1;
    logic [DQ_W-1:0] q;
    logic [1:0] m0;
    logic [1:0] oe;
  } sdp_state_s;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [9:0] burst_len(input logic [2:0] bl);
    unique case (bl)
      3'h1: return 10'h002;
      3'h2: return 10'h004;
      3'h3: return 10'h008;
      BL_FULL: return FULL_PAGE_LEN;
      default: return 10'h001;
    endcase
  endfunction

  // column of beat c; wraps inside the burst-length boundary
  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] s,
                                              input logic [COL_W-1:0] c,
                                              input logic [2:0] bl,
                                              input logic bt);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] lo;
    m = COL_W'(burst_len(bl) - 10'h001);
    lo = bt ? (s ^ c) : COL_W'(s + c);
    return (s & ~m) | (lo & m);
  endfunction

endpackage

// ==== hdl/sdp_sdram_pins.sv ====
// sdp_sdram_pins: pin-level command decoder, burst engine and data bus of a
// four-bank 16-bit synchronous dram. pins are driven by a controller on the
// same clock, so no synchronisers; dq is split into in, out and enable.
`timescale 1ns/1ps

module sdp_sdram_pins (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // command and address
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdp_pkg::ADDR_W-1:0] addr,
  input wire logic bank_select_lsb,
  input wire logic bank_select_msb,
  // byte masks
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  // data bus
  input wire logic [sdp_pkg::DQ_W-1:0] dq_in,
  output logic [sdp_pkg::DQ_W-1:0] dq_out,
  output logic [1:0] dq_oe,
  // power status
  output logic power_down,
  output logic clock_suspended,
  output logic self_refresh
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sdp_pkg::sdp_state_s st_r;
  sdp_pkg::sdp_state_s st_nxt;
  logic [sdp_pkg::DQ_W-1:0] mem [2**sdp_pkg::MEM_AW];
  logic [sdp_pkg::MEM_AW-1:0] mem_idx;
  logic [1:0] mem_we;
  logic [2:0] cmd;
  logic [1:0] bank;
  logic live;
  logic op;
  logic [sdp_pkg::COL_W-1:0] op_col;

  assign bank = {bank_select_msb, bank_select_lsb};
  assign live = cke && (st_r.pwr == sdp_pkg::PWR_RUN);
  assign cmd = cs_n ? sdp_pkg::CMD_NOP : {ras_n, cas_n, we_n};

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    op = 1'b0;
    mem_we = 2'b00;
    op_col = '0;
    mem_idx = '0;
    if (!cke) begin
      // internal clock stopped: everything holds, only the mode is chosen
      if (st_r.pwr == sdp_pkg::PWR_RUN) begin
        if (cmd == sdp_pkg::CMD_REF) begin
          st_nxt.pwr = sdp_pkg::PWR_SREF;
        end else if (st_r.rd || st_r.wr || st_r.v0 || st_r.v1) begin
          st_nxt.pwr = sdp_pkg::PWR_SUSP;
        end else begin
          st_nxt.pwr = sdp_pkg::PWR_PDN;
        end
      end
    end else if (st_r.pwr == sdp_pkg::PWR_SREF || st_r.pwr == sdp_pkg::PWR_PDN) begin
      // exit edge takes no command; controller is expected to send nop
      st_nxt.pwr = sdp_pkg::PWR_RUN;
    end else begin
      st_nxt.pwr = sdp_pkg::PWR_RUN;
      // read pipeline and output stage
      st_nxt.p1 = st_r.p0;
      st_nxt.v1 = st_r.v0;
      st_nxt.v0 = 1'b0;
      st_nxt.q = st_r.cl3 ? st_r.p1 : st_r.p0;
      st_nxt.m0 = {upper_byte_mask, lower_byte_mask};
      st_nxt.oe = {2{st_r.cl3 ? st_r.v1 : st_r.v0}} & ~st_r.m0;
      // running burst
      if (st_r.rd || st_r.wr) begin
        if (st_r.left != 10'h000) begin
          st_nxt.cnt = sdp_pkg::COL_W'(st_r.cnt + 9'h001);
          if (!st_r.full) begin
            st_nxt.left = st_r.left - 10'h001;
          end
          op = 1'b1;
        end else begin
          st_nxt.rd = 1'b0;
          st_nxt.wr = 1'b0;
          if (st_r.ap) begin
            st_nxt.act[st_r.bank] = 1'b0;
          end
        end
      end
      unique case (cmd)
        sdp_pkg::CMD_MRS: begin
          st_nxt.bl = addr[sdp_pkg::MR_BL_LSB +: 3];
          st_nxt.bt = addr[sdp_pkg::MR_BT_BIT];
          st_nxt.cl3 = addr[sdp_pkg::MR_CL_LSB +: 3] == sdp_pkg::CL3_CODE;
          st_nxt.wbs = addr[sdp_pkg::MR_WBS_BIT];
        end
        sdp_pkg::CMD_ACT: begin
          st_nxt.act[bank] = 1'b1;
          st_nxt.row[bank] = addr;
        end
        sdp_pkg::CMD_RD, sdp_pkg::CMD_WR: begin
          if (st_r.act[bank]) begin
            st_nxt.rd = cmd == sdp_pkg::CMD_RD;
            st_nxt.wr = cmd == sdp_pkg::CMD_WR;
            st_nxt.bank = bank;
            st_nxt.col0 = addr[sdp_pkg::COL_W-1:0];
            st_nxt.cnt = '0;
            if (cmd == sdp_pkg::CMD_WR && st_r.wbs) begin
              st_nxt.left = 10'h000;
              st_nxt.full = 1'b0;
            end else begin
              st_nxt.left = sdp_pkg::burst_len(st_r.bl) - 10'h001;
              st_nxt.full = st_r.bl == sdp_pkg::BL_FULL;
            end
            st_nxt.ap = addr[sdp_pkg::AP_BIT];
            op = 1'b1;
          end
        end
        sdp_pkg::CMD_BST: begin
          st_nxt.rd = 1'b0;
          st_nxt.wr = 1'b0;
          op = 1'b0;
        end
        sdp_pkg::CMD_PRE: begin
          if (addr[sdp_pkg::AP_BIT]) begin
            st_nxt.act = 4'h0;
          end else begin
            st_nxt.act[bank] = 1'b0;
          end
          if (addr[sdp_pkg::AP_BIT] || bank == st_r.bank) begin
            st_nxt.rd = 1'b0;
            st_nxt.wr = 1'b0;
            op = 1'b0;
          end
        end
        sdp_pkg::CMD_REF: begin
        end
        sdp_pkg::CMD_NOP: begin
        end
      endcase
      op_col = sdp_pkg::col_at(st_nxt.col0, st_nxt.cnt, st_nxt.bl, st_nxt.bt);
      mem_idx = {st_nxt.bank, st_nxt.row[st_nxt.bank][sdp_pkg::MEM_ROW_BITS-1:0], op_col};
      if (op && st_nxt.rd) begin
        st_nxt.p0 = mem[mem_idx];
        st_nxt.v0 = 1'b1;
      end
      if (op && st_nxt.wr) begin
        mem_we = ~{upper_byte_mask, lower_byte_mask};
      end
      // write takes the bus: drop queued read data so only one side drives
      if (st_nxt.wr) begin
        st_nxt.v0 = 1'b0;
        st_nxt.v1 = 1'b0;
        st_nxt.oe = 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.pwr <= sdp_pkg::PWR_RUN;
      st_r.bl <= sdp_pkg::BL_RST;
      st_r.cl3 <= sdp_pkg::CL3_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // cell array has no reset, like the real cells
  always_ff @(posedge clock) begin
    if (mem_we[0]) begin
      mem[mem_idx][7:0] <= dq_in[7:0];
    end
    if (mem_we[1]) begin
      mem[mem_idx][15:8] <= dq_in[15:8];
    end
  end

  assign dq_out = st_r.q;
  assign dq_oe = st_r.oe;
  assign power_down = st_r.pwr == sdp_pkg::PWR_PDN;
  assign clock_suspended = st_r.pwr == sdp_pkg::PWR_SUSP;
  assign self_refresh = st_r.pwr == sdp_pkg::PWR_SREF;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic rd_go;
  logic wr_go;
  logic [sdp_pkg::MEM_AW-1:0] chk_idx_r;
  logic [7:0] chk_lo_r;
  assign rd_go = live && cmd == sdp_pkg::CMD_RD && st_r.act[bank];
  assign wr_go = live && cmd == sdp_pkg::CMD_WR && st_r.act[bank];

  always_ff @(posedge clock) begin
    chk_idx_r <= mem_idx;
    chk_lo_r <= mem[mem_idx][7:0];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_rd_cl2;
    (rd_go && !st_r.cl3 && !lower_byte_mask) ##1 (cke && !wr_go);
  endsequence
  sequence s_rd_cl3;
    (rd_go && st_r.cl3) ##1 (cke && !lower_byte_mask && !wr_go) ##1 (cke && !wr_go);
  endsequence

  a_cl2_latency: assert property (s_rd_cl2 |-> ##1 dq_oe[0])
    else $error("cl2 read data not driven");
  a_cl3_latency: assert property (s_rd_cl3 |-> ##1 dq_oe[0])
    else $error("cl3 read data not driven");
  a_mask_lower: assert property (live && lower_byte_mask ##1 cke |-> ##1 !dq_oe[0])
    else $error("lower byte not floated after mask");
  a_mask_upper: assert property (live && upper_byte_mask ##1 cke |-> ##1 !dq_oe[1])
    else $error("upper byte not floated after mask");
  a_wr_mask: assert property (wr_go && lower_byte_mask |=> mem[chk_idx_r][7:0] == chk_lo_r)
    else $error("masked write byte changed");
  a_bus_single: assert property (st_r.wr |-> dq_oe == 2'b00)
    else $error("data driven during write burst");
  // auto precharge may legally close a bank under deselect
  a_cs_ignore: assert property (cke && cs_n && !st_r.ap |=> $stable(st_r.act) && $stable(st_r.row) && $stable(st_r.bl))
    else $error("command taken with chip select high");
  a_cs_burst: assert property (live && cs_n && st_r.rd && st_r.left != 10'h000 |=> st_r.rd)
    else $error("burst stopped by deselect");
  a_act_row: assert property (live && cmd == sdp_pkg::CMD_ACT |=> st_r.act[$past(bank)] && st_r.row[$past(bank)] == $past(addr))
    else $error("row not opened");
  a_mode_cl: assert property (live && cmd == sdp_pkg::CMD_MRS |=> st_r.cl3 == ($past(addr[6:4]) == 3'h3))
    else $error("mode latency not taken");
  a_burst_len4: assert property (rd_go && st_r.bl == 3'h2 |=> st_r.rd && st_r.left == 10'h003)
    else $error("burst of four mis-loaded");
  a_sref_entry: assert property (st_r.pwr == sdp_pkg::PWR_RUN && !cke && cmd == sdp_pkg::CMD_REF |=> self_refresh)
    else $error("self refresh not entered");
  a_cke_freeze: assert property (!cke |=> $stable(st_r.left) && $stable(st_r.oe))
    else $error("state moved with clock enable low");

endmodule // sdp_sdram_pins

// ==== sim/sdp_ctrl_model.sv ====
// sdp_ctrl_model: behavioural memory controller driving the sdram pins
// assumes the bench calls issue() once per cycle, just after a rising edge
`timescale 1ns/1ps

module sdp_ctrl_model (
  // clock
  input wire logic clock,
  // command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [sdp_pkg::ADDR_W-1:0] addr,
  output logic bank_select_lsb,
  output logic bank_select_msb,
  output logic lower_byte_mask,
  output logic upper_byte_mask,
  // data bus
  input wire logic [sdp_pkg::DQ_W-1:0] dq_out,
  input wire logic [1:0] dq_oe,
  output logic [sdp_pkg::DQ_W-1:0] dq_in
);
  logic [15:0] wd = 16'h0000;
  logic drv = 1'b0;
  logic [15:0] last = 16'h0000;

  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = sdp_pkg::CMD_NOP;
    addr = 13'h0000;
    {bank_select_msb, bank_select_lsb} = 2'h0;
    {upper_byte_mask, lower_byte_mask} = 2'h0;
  end

  // ----------------------------------------------------------------------
  // bus level
  // ----------------------------------------------------------------------
  // an undriven byte toggles so a stale value can never pass for data
  always_comb begin
    dq_in[7:0] = dq_oe[0] ? dq_out[7:0] : (drv ? wd[7:0] : ~last[7:0]);
    dq_in[15:8] = dq_oe[1] ? dq_out[15:8] : (drv ? wd[15:8] : ~last[15:8]);
  end

  always @(posedge clock) last <= dq_in;

  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [1:0] m, input logic sel_n, input logic ck,
                       input logic [15:0] d, input logic dr);
    cke = ck;
    cs_n = sel_n;
    {ras_n, cas_n, we_n} = c;
    addr = a;
    {bank_select_msb, bank_select_lsb} = b;
    {upper_byte_mask, lower_byte_mask} = m;
    wd = d;
    drv = dr;
    @(posedge clock);
    #1;
  endtask
endmodule // sdp_ctrl_model

// ==== sim/tb_sdram_pin_command_interface.sv ====
// tb_sdram_pin_command_interface: self-checking bench for sdp_sdram_pins
// assumes sdp_pkg and sdp_ctrl_model are compiled before this file
`timescale 1ns/1ps
`define CHK(act, exp) begin \
  compares++; \
  if ((act) !== (exp)) begin \
    n_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (act), (exp)); \
  end \
end

module tb_sdram_pin_command_interface;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, bsl, bsm, lbm, ubm, pd, cs, sr;
  logic [12:0] addr;
  logic [15:0] dq_in, dq_out;
  logic [1:0] dq_oe;
  int n_errors = 0;
  int compares = 0;
  logic [15:0] lf = 16'h002e;
  logic [15:0] mem [int];
  logic [12:0] row [4];

  always #2.5 clock = ~clock;

  sdp_sdram_pins uut (.clock(clock), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_lsb(bsl), .bank_select_msb(bsm),
    .lower_byte_mask(lbm), .upper_byte_mask(ubm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .power_down(pd), .clock_suspended(cs), .self_refresh(sr));

  sdp_ctrl_model ctl (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .addr(addr), .bank_select_lsb(bsl), .bank_select_msb(bsm),
    .lower_byte_mask(lbm), .upper_byte_mask(ubm), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  function automatic int key(int b, int s, int k, int bl, int bt);
    int m;
    m = bl - 1;
    return b * 1024 + row[b][0] * 512 + ((s & ~m) | (((bt != 0) ? (s ^ k) : (s + k)) & m));
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // first pass unmasked so every byte is known before masked beats
  task automatic do_write(input int b, input int s, input int bl, input int bt, input bit mo);
    logic [15:0] d;
    logic [15:0] r;
    logic [15:0] e;
    logic [1:0] m;
    int a;
    for (int k = 0; k < bl; k++) begin
      d = rnd();
      r = rnd();
      m = mo ? (r[1:0] & r[3:2]) : 2'h0;
      a = key(b, s, k, bl, bt);
      e = mem.exists(a) ? mem[a] : 16'h0000;
      if (!m[0]) e[7:0] = d[7:0];
      if (!m[1]) e[15:8] = d[15:8];
      mem[a] = e;
      if (k == 0) ctl.issue(sdp_pkg::CMD_WR, 2'(b), 13'(s), m, 1'b0, 1'b1, d, 1'b1);
      else ctl.issue(r[4] ? sdp_pkg::CMD_RD : sdp_pkg::CMD_NOP, 2'(b), 13'h0, m, r[4], 1'b1,
                     d, 1'b1);
    end
  endtask

  task automatic do_read(input int b, input int s, input int bl, input int bt, input int cl);
    logic [1:0] mk [0:15];
    logic [15:0] r;
    logic [15:0] e;
    r = rnd();
    mk[0] = r[1:0] & r[3:2];
    ctl.issue(sdp_pkg::CMD_RD, 2'(b), 13'(s), mk[0], 1'b0, 1'b1, 16'h0, 1'b0);
    for (int t = 1; t <= cl + bl; t++) begin
      if (t >= cl && t < cl + bl) begin
        e = mem[key(b, s, t - cl, bl, bt)];
        `CHK(dq_oe, ~mk[t-2])
        if (!mk[t-2][0]) `CHK(dq_out[7:0], e[7:0])
        if (!mk[t-2][1]) `CHK(dq_out[15:8], e[15:8])
      end else begin
        `CHK(dq_oe, 2'h0)
      end
      r = rnd();
      mk[t] = r[1:0] & r[3:2];
      ctl.issue(r[4] ? sdp_pkg::CMD_WR : sdp_pkg::CMD_NOP, 2'(b), 13'h0, mk[t], r[4], 1'b1,
                16'h0, 1'b0);
    end
  endtask

  // mid-cycle look: both sides have settled since the last rising edge
  always @(negedge clock) begin
    if (!rst && ctl.drv) `CHK(dq_oe, 2'h0)
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] r;
    int b;
    int s;
    logic [15:0] e;
    repeat (16) @(posedge clock);
    #1;
    `CHK({dq_oe, pd, cs, sr}, 5'h00)
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      b = r[1:0];
      s = r[12:4];
      r = rnd();
      row[b] = r[12:0];
      ctl.issue(sdp_pkg::CMD_MRS, 2'h0, {6'h00, (i[3] ? 3'h3 : 3'h2), i[2], 3'(i % 4)},
                2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
      ctl.issue(sdp_pkg::CMD_PRE, 2'h0, 13'h0400, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
      ctl.issue(sdp_pkg::CMD_ACT, 2'(b), row[b], 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
      do_write(b, s, 1 << (i % 4), i[2], 1'b0);
      do_write(b, s, 1 << (i % 4), i[2], 1'b1);
      do_read(b, s, 1 << (i % 4), i[2], i[3] ? 3 : 2);
      $display("test mode %0d done", i);
    end
    ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b0, 16'h0, 1'b0);
    `CHK({pd, cs, sr}, 3'h4)
    ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    `CHK({pd, cs, sr}, 3'h0)
    ctl.issue(sdp_pkg::CMD_REF, 2'h0, 13'h0, 2'h0, 1'b0, 1'b0, 16'h0, 1'b0);
    `CHK({pd, cs, sr}, 3'h1)
    ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    `CHK({pd, cs, sr}, 3'h0)
    ctl.issue(sdp_pkg::CMD_MRS, 2'h0, 13'h0023, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    ctl.issue(sdp_pkg::CMD_RD, 2'(b), 13'(s), 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b0, 16'h0, 1'b0);
    `CHK({pd, cs, sr}, 3'h2)
    // suspended read resumes where it stopped: beat k right after resume edge k
    for (int t = 0; t < 12; t++) begin
      ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
      e = mem[key(b, s, t, 8, 0)];
      if (t < 8) `CHK({dq_oe, dq_out}, {2'h3, e})
      else `CHK(dq_oe, 2'h0)
    end
    `CHK({dq_oe, pd, cs, sr}, 5'h00)
    $display("test power modes done");
    // full page write and read, each ended by burst stop
    ctl.issue(sdp_pkg::CMD_MRS, 2'h0, 13'h0027, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    do_write(b, s, 512, 0, 1'b0);
    ctl.issue(sdp_pkg::CMD_BST, 2'(b), 13'h0, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    ctl.issue(sdp_pkg::CMD_RD, 2'(b), 13'(s), 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    for (int t = 1; t < 14; t++) begin
      e = mem[key(b, s, t - 2, 512, 0)];
      if (t >= 2 && t < 12) `CHK({dq_oe, dq_out}, {2'h3, e})
      else `CHK(dq_oe, 2'h0)
      ctl.issue((t == 10) ? sdp_pkg::CMD_BST : sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0,
                1'b1, 16'h0, 1'b0);
    end
    // auto precharge closes the bank, so the next read is ignored
    ctl.issue(sdp_pkg::CMD_MRS, 2'h0, 13'h0020, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    ctl.issue(sdp_pkg::CMD_RD, 2'(b), 13'h0400 | 13'(s), 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    `CHK({dq_oe, dq_out}, {2'h3, mem[key(b, s, 0, 1, 0)]})
    ctl.issue(sdp_pkg::CMD_RD, 2'(b), 13'(s), 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    `CHK(dq_oe, 2'h0)
    ctl.issue(sdp_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    `CHK(dq_oe, 2'h0)
    $display("test page and precharge done");
    wrap_up();
  end

  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule // tb_sdram_pin_command_interface
